// ### hdl/ssq_regs.svh
// Register offsets, opcodes, error codes, sizes and reset values of the
// source list / memory sweep sequencer.
// Assumes inclusion by ssq_pkg and by the design modules.
`ifndef SSQ_REGS_SVH
`define SSQ_REGS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define SSQ_OFF_CMD       8'h00
`define SSQ_OFF_LIST_DATA 8'h04
`define SSQ_OFF_SETUP_LO  8'h08
`define SSQ_OFF_SETUP_HI  8'h0C
`define SSQ_OFF_STATUS    8'h10
`define SSQ_OFF_CUR_LEN   8'h14
`define SSQ_OFF_VOLT_LEN  8'h18
`define SSQ_OFF_MEM_CFG   8'h1C
`define SSQ_OFF_ERR       8'h20

// ----------------------------------------------------------------------
// Command word: opcode in [7:0], argument in [15:8]
// ----------------------------------------------------------------------
`define SSQ_CMD_OP_LSB    0
`define SSQ_CMD_ARG_LSB   8
`define SSQ_OP_DEF_CUR    8'h01
`define SSQ_OP_DEF_VOLT   8'h02
`define SSQ_OP_ADD_CUR    8'h03
`define SSQ_OP_ADD_VOLT   8'h04
`define SSQ_OP_RUN_CUR    8'h05
`define SSQ_OP_RUN_VOLT   8'h06
`define SSQ_OP_RUN_MEM    8'h07
`define SSQ_OP_MEM_INIT   8'h08
`define SSQ_OP_SAVE       8'h09
`define SSQ_OP_RECALL     8'h0A
`define SSQ_OP_MEM_START  8'h0B
`define SSQ_OP_MEM_POINTS 8'h0C

// ----------------------------------------------------------------------
// Error codes
// ----------------------------------------------------------------------
`define SSQ_ERR_NONE      10'h000
`define SSQ_ERR_REVISED   10'h329
`define SSQ_ERR_RANGE     10'h0DE
`define SSQ_ERR_LIST_FULL 10'h0DF
`define SSQ_ERR_BUSY      10'h0C8
`define SSQ_ERR_CMD       10'h071

// ----------------------------------------------------------------------
// Sizes and reset values
// ----------------------------------------------------------------------
`define SSQ_MEM_LOCS      100
`define SSQ_LOC_FIRST     7'h01
`define SSQ_LOC_LAST      7'h64
`define SSQ_LIST_DEPTH    2500
`define SSQ_LIST_BATCH    100
`define SSQ_VAL_W         16
`define SSQ_LEN_W         12
`define SSQ_EXPR_POWER    3'h0
`define SSQ_RST_START     7'h01
`define SSQ_RST_POINTS    7'h01

`endif

// ### hdl/ssq_pkg.sv
// Types shared by the sequencer core and its list store.
// Assumes ssq_regs.svh is on the include path.
`include "ssq_regs.svh"

package ssq_pkg;

  // One stored instrument setup: low 32 bits in SETUP_LO, value in HI
  typedef struct packed {
    logic [15:0] srcValue;
    logic [3:0]  timing;
    logic        limitOn;
    logic        nullOn;
    logic [2:0]  exprId;
    logic        mathOn;
    logic        rearTerm;
    logic        remoteSense;
    logic        autoZero;
    logic [2:0]  compRange;
    logic        srcAuto;
    logic [2:0]  srcRange;
    logic        srcFunc;
    logic [2:0]  avgCount;
    logic        avgOn;
    logic [2:0]  senseFunc;
    logic [3:0]  integCycles;
  } ssq_setup_t;

  typedef enum logic [2:0] {
    SSQ_IDLE       = 3'b000,
    SSQ_LIST_APPLY = 3'b001,
    SSQ_LIST_WAIT  = 3'b010,
    SSQ_MEM_APPLY  = 3'b011,
    SSQ_MEM_WAIT   = 3'b100
  } ssq_state_t;

  // Control strobes toward one list store
  typedef struct packed {
    logic clr;
    logic open;
    logic wr;
  } ssq_list_req_t;

  typedef struct packed {
    ssq_state_t                          st;
    ssq_setup_t [`SSQ_MEM_LOCS-1:0]      mem;
    ssq_setup_t                          present;
    ssq_setup_t                          active;
    logic [6:0]                          memStart;
    logic [6:0]                          memPoints;
    logic [6:0]                          loc;
    logic [6:0]                          done;
    logic [`SSQ_LEN_W-1:0]               idx;
    logic                                runVolt;
    logic                                addOpen;
    logic                                addVolt;
    logic [9:0]                          errCode;
    logic                                errFlag;
    logic [31:0]                         rdata;
    logic [`SSQ_VAL_W-1:0]               srcLevel;
    logic                                srcIsVolt;
    logic                                srcStrobe;
    logic                                measTrig;
    logic                                busy;
  } ssq_core_t;

endpackage

// ### hdl/ssq_list_store.sv
// One source list: flip-flop storage filled in batches, read by index.
// Assumes strobes come from the core on the same clock, one at a time.
`timescale 1ns/1ps
`include "ssq_regs.svh"

module ssq_list_store #(
  parameter int DEPTH = `SSQ_LIST_DEPTH,
  parameter int BATCH = `SSQ_LIST_BATCH,
  parameter int WIDTH = `SSQ_VAL_W,
  parameter int LW    = `SSQ_LEN_W
) (
  input  wire logic                  clk_sys,
  input  wire logic                  rst_n,
  input  ssq_pkg::ssq_list_req_t     req,
  input  wire logic [WIDTH-1:0]      wrData,
  input  wire logic [LW-1:0]         rdIdx,
  output logic      [WIDTH-1:0]      rdData,
  output logic      [LW-1:0]         length,
  output logic                       full
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] ent;
    logic [LW-1:0]               len;
    logic [7:0]                  batch;
  } store_t;

  store_t q;
  store_t d;

  assign rdData = q.ent[rdIdx];
  assign length = q.len;
  // Refuse once a batch or the whole store is used up
  assign full = (q.batch >= 8'(BATCH)) || (q.len >= LW'(DEPTH)); // [RULE1]

  always_comb begin
    d = q;
    if (req.clr) begin
      d.len   = '0;
      d.batch = '0;
    end else if (req.open) begin
      d.batch = '0;
    end else if (req.wr && !full) begin
      d.ent[q.len] = wrData; // [RULE4]
      d.len        = q.len + 1'b1; // [RULE5]
      d.batch      = q.batch + 8'h01;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_BATCH_CAP: assert property (q.batch <= 8'(BATCH)) // [RULE1]
    else $error("list batch above limit");
  AST_ADD_KEEPS: assert property ( // [RULE4]
    (req.wr && !full && !req.clr && !req.open) |=>
      (q.len == $past(q.len) + 1'b1) && (q.ent[$past(q.len)] == $past(wrData)))
    else $error("list_add_cmd did not land at list end");
  AST_TOTAL_CAP: assert property (q.len <= LW'(DEPTH)) // [RULE5]
    else $error("list length above storage depth");

endmodule

// ### hdl/ssq_core.sv
// Source list and setup memory sweep sequencer with its register port.
// Assumes measDone and exprPresent come from logic on clk_sys; the host
// keeps arm and trigger counts consistent with the sweep it starts.
//
// Contract
// RULE1: one list definition takes at most 100 values, replacing the list.
// RULE2: a list run outputs every stored value in order from entry one.
// RULE3: exactly one measurement trigger per applied source level.
// RULE4: list_add_cmd adds up to 100 values after the end, earlier ones kept.
// RULE5: repeated appends let a list hold up to 2500 entries.
// RULE6: a length read returns the values stored in that list.
// RULE7: host selects list mode, arm times trigger at least list length.
// RULE8: setup memory has 100 locations, each one complete setup.
// RULE9: host selects memory function, trigger count equals sweep points.
// RULE10: host keeps arm times trigger count at least the sweep points.
// RULE11: memory init copies present setup everywhere, first math stage off.
// RULE12: memory init swaps user math expressions for the power expression.
// RULE13: missing expression in sweep raises 809, disables that math stage.
// RULE14: save with location 1 to 100 stores present setup there.
// RULE15: snapshot covers sense, source, ranges, math, null, limit, timing.
// RULE16: host stores sweep setups consecutively unless pass branching.
// RULE17: point count 1 to 100 sets locations executed per sweep.
// RULE18: start location 1 to 100 sets first executed location.
// RULE19: recall of location 1 to 100 restores its whole setup.
// RULE20: host may enable source autorange for lists spanning ranges.
// RULE21: sweep location wraps from 100 to 1 until point count reached.
// RULE22: out-of-range location or count is rejected with an error.
`timescale 1ns/1ps
`include "ssq_regs.svh"

module ssq_core (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_n,
  input  wire logic [7:0]               regAddr,
  input  wire logic [31:0]              regWdata,
  input  wire logic                     regWr,
  input  wire logic                     regRd,
  output logic      [31:0]              regRdata,
  input  wire logic                     measDone,
  input  wire logic [7:0]               exprPresent,
  output logic      [`SSQ_VAL_W-1:0]    srcLevel,
  output logic                          srcIsVolt,
  output logic                          srcStrobe,
  output logic                          measTrig,
  output ssq_pkg::ssq_setup_t           activeSetup,
  output logic                          seqBusy
);

  // --------------------------------------------------------------------
  // State and list stores
  // --------------------------------------------------------------------
  ssq_pkg::ssq_core_t     q;
  ssq_pkg::ssq_core_t     d;
  ssq_pkg::ssq_list_req_t listReq [2];
  logic [`SSQ_VAL_W-1:0]  listRd  [2];
  logic [`SSQ_LEN_W-1:0]  listLen [2];
  logic                   listFull [2];

  generate
    for (genvar g = 0; g < 2; g++) begin : gList
      ssq_list_store u_store (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .req     (listReq[g]),
        .wrData  (regWdata[`SSQ_VAL_W-1:0]),
        .rdIdx   (q.idx),
        .rdData  (listRd[g]),
        .length  (listLen[g]),
        .full    (listFull[g])
      );
    end
  endgenerate

  assign regRdata    = q.rdata;
  assign srcLevel    = q.srcLevel;
  assign srcIsVolt   = q.srcIsVolt;
  assign srcStrobe   = q.srcStrobe;
  assign measTrig    = q.measTrig;
  assign activeSetup = q.active;
  assign seqBusy     = q.busy;

  // --------------------------------------------------------------------
  // Command decode helpers
  // --------------------------------------------------------------------
  logic [7:0] cmdOp;
  logic [7:0] cmdArg;
  logic       argOk;
  logic [6:0] argIdx;
  logic [6:0] curIdx;
  logic       exprMissing;
  logic       lastPoint;

  assign cmdOp  = regWdata[`SSQ_CMD_OP_LSB +: 8];
  assign cmdArg = regWdata[`SSQ_CMD_ARG_LSB +: 8];
  assign argOk  = (cmdArg >= 8'h01) && (cmdArg <= 8'h64); // [RULE22]
  assign argIdx = 7'(cmdArg - 8'h01);
  assign curIdx = q.loc - 7'h01;
  // Built-in power expression always exists; user slots must be present
  assign exprMissing = q.mem[curIdx].mathOn
                    && (q.mem[curIdx].exprId != `SSQ_EXPR_POWER)
                    && !exprPresent[q.mem[curIdx].exprId];
  assign lastPoint = (q.done + 7'h01) >= q.memPoints;

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    logic [9:0] errSet;
    errSet      = `SSQ_ERR_NONE;
    d           = q;
    d.rdata     = '0;
    d.srcStrobe = 1'b0;
    d.measTrig  = 1'b0;
    for (int i = 0; i < 2; i++) begin
      listReq[i] = '0;
    end

    if (regRd) begin
      case (regAddr)
        `SSQ_OFF_SETUP_LO:  d.rdata = q.present[31:0];
        `SSQ_OFF_SETUP_HI:  d.rdata = {16'h0000, q.present.srcValue};
        `SSQ_OFF_STATUS:    d.rdata = {24'h000000, q.addVolt, q.addOpen,
                                       q.runVolt, q.busy, 1'b0, q.st};
        `SSQ_OFF_CUR_LEN:   d.rdata = {20'h00000, listLen[0]}; // [RULE6]
        `SSQ_OFF_VOLT_LEN:  d.rdata = {20'h00000, listLen[1]}; // [RULE6]
        `SSQ_OFF_MEM_CFG:   d.rdata = {9'h000, q.loc, 1'b0, q.memPoints,
                                       1'b0, q.memStart};
        `SSQ_OFF_ERR:       d.rdata = {21'h000000, q.errFlag, q.errCode};
        default:            d.rdata = '0;
      endcase
    end

    if (regWr) begin
      case (regAddr)
        `SSQ_OFF_CMD: begin
          if (q.busy) begin
            errSet = `SSQ_ERR_BUSY;
          end else begin
            case (cmdOp)
              `SSQ_OP_DEF_CUR, `SSQ_OP_DEF_VOLT: begin
                listReq[cmdOp[1] ? 1 : 0].clr = 1'b1; // [RULE1]
                d.addOpen = 1'b1;
                d.addVolt = cmdOp[1];
              end
              `SSQ_OP_ADD_CUR, `SSQ_OP_ADD_VOLT: begin
                listReq[cmdOp[0] ? 0 : 1].open = 1'b1; // [RULE4]
                d.addOpen = 1'b1;
                d.addVolt = !cmdOp[0];
              end
              `SSQ_OP_RUN_CUR, `SSQ_OP_RUN_VOLT: begin
                if (listLen[cmdOp[0] ? 0 : 1] == '0) begin
                  errSet = `SSQ_ERR_CMD;
                end else begin
                  d.st      = ssq_pkg::SSQ_LIST_APPLY;
                  d.idx     = '0; // [RULE2]
                  d.runVolt = !cmdOp[0];
                  d.busy    = 1'b1;
                  d.addOpen = 1'b0;
                end
              end
              `SSQ_OP_RUN_MEM: begin
                d.st   = ssq_pkg::SSQ_MEM_APPLY;
                d.loc  = q.memStart; // [RULE18]
                d.done = '0;
                d.busy = 1'b1;
              end
              `SSQ_OP_MEM_INIT: begin
                for (int i = 0; i < `SSQ_MEM_LOCS; i++) begin
                  d.mem[i]        = q.present; // [RULE8]
                  d.mem[i].mathOn = 1'b0; // [RULE11]
                  d.mem[i].exprId = `SSQ_EXPR_POWER; // [RULE12]
                end
              end
              `SSQ_OP_SAVE: begin
                if (argOk) begin
                  d.mem[argIdx] = q.present; // [RULE14] [RULE15]
                end else begin
                  errSet = `SSQ_ERR_RANGE; // [RULE22]
                end
              end
              `SSQ_OP_RECALL: begin
                if (argOk) begin
                  d.present = q.mem[argIdx]; // [RULE19]
                  d.active  = q.mem[argIdx];
                end else begin
                  errSet = `SSQ_ERR_RANGE; // [RULE22]
                end
              end
              `SSQ_OP_MEM_START: begin
                if (argOk) begin
                  d.memStart = cmdArg[6:0]; // [RULE18]
                end else begin
                  errSet = `SSQ_ERR_RANGE; // [RULE22]
                end
              end
              `SSQ_OP_MEM_POINTS: begin
                if (argOk) begin
                  d.memPoints = cmdArg[6:0]; // [RULE17]
                end else begin
                  errSet = `SSQ_ERR_RANGE; // [RULE22]
                end
              end
              default: errSet = `SSQ_ERR_CMD;
            endcase
          end
        end
        `SSQ_OFF_LIST_DATA: begin
          // Data outside an open batch, or during a run, is refused
          if (q.busy || !q.addOpen || listFull[q.addVolt ? 1 : 0]) begin
            errSet = `SSQ_ERR_LIST_FULL;
          end else begin
            listReq[q.addVolt ? 1 : 0].wr = 1'b1;
          end
        end
        `SSQ_OFF_SETUP_LO: begin
          if (!q.busy) begin
            d.present = ssq_pkg::ssq_setup_t'({q.present.srcValue, regWdata});
          end
        end
        `SSQ_OFF_SETUP_HI: begin
          if (!q.busy) begin
            d.present.srcValue = regWdata[15:0];
          end
        end
        `SSQ_OFF_ERR: begin
          d.errFlag = 1'b0;
          d.errCode = `SSQ_ERR_NONE;
        end
        default: ;
      endcase
    end

    case (q.st)
      ssq_pkg::SSQ_IDLE: ;
      ssq_pkg::SSQ_LIST_APPLY: begin
        d.srcLevel  = listRd[q.runVolt ? 1 : 0]; // [RULE2]
        d.srcIsVolt = q.runVolt;
        d.srcStrobe = 1'b1;
        d.measTrig  = 1'b1; // [RULE3]
        d.st        = ssq_pkg::SSQ_LIST_WAIT;
      end
      ssq_pkg::SSQ_LIST_WAIT: begin
        if (measDone) begin
          if (q.idx + 1'b1 >= listLen[q.runVolt ? 1 : 0]) begin
            d.st   = ssq_pkg::SSQ_IDLE;
            d.busy = 1'b0;
          end else begin
            d.idx = q.idx + 1'b1; // [RULE2]
            d.st  = ssq_pkg::SSQ_LIST_APPLY;
          end
        end
      end
      ssq_pkg::SSQ_MEM_APPLY: begin
        d.active = q.mem[curIdx];
        if (exprMissing) begin
          // Location is revised in place so later sweeps stay clean
          d.mem[curIdx].mathOn = 1'b0; // [RULE13]
          d.active.mathOn      = 1'b0;
          errSet               = `SSQ_ERR_REVISED; // [RULE13]
        end
        d.srcLevel  = q.mem[curIdx].srcValue;
        d.srcIsVolt = q.mem[curIdx].srcFunc;
        d.srcStrobe = 1'b1;
        d.measTrig  = 1'b1; // [RULE3]
        d.st        = ssq_pkg::SSQ_MEM_WAIT;
      end
      ssq_pkg::SSQ_MEM_WAIT: begin
        if (measDone) begin
          d.done = q.done + 7'h01;
          if (lastPoint) begin
            d.st   = ssq_pkg::SSQ_IDLE; // [RULE17]
            d.busy = 1'b0;
          end else begin
            d.loc = (q.loc == `SSQ_LOC_LAST) ? `SSQ_LOC_FIRST
                                              : q.loc + 7'h01; // [RULE21]
            d.st  = ssq_pkg::SSQ_MEM_APPLY;
          end
        end
      end
      default: begin
        d.st   = ssq_pkg::SSQ_IDLE;
        d.busy = 1'b0;
      end
    endcase

    // Raised errors win over a clear in the same cycle
    if (errSet != `SSQ_ERR_NONE) begin
      d.errFlag = 1'b1;
      d.errCode = errSet;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      q           <= '0;
      q.memStart  <= `SSQ_RST_START;
      q.memPoints <= `SSQ_RST_POINTS;
      q.loc       <= `SSQ_LOC_FIRST;
    end else begin
      q <= d;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_ONE_TRIG_PER_LEVEL: assert property ( // [RULE3]
    srcStrobe |-> measTrig ##1 !measTrig)
    else $error("source level without exactly one trigger");
  AST_LIST_FROM_FIRST: assert property ( // [RULE2]
    (q.st == ssq_pkg::SSQ_IDLE) ##1 (q.st == ssq_pkg::SSQ_LIST_APPLY)
      |-> (q.idx == '0))
    else $error("list run did not start at first entry");
  AST_LIST_NEXT: assert property ( // [RULE2]
    (q.st == ssq_pkg::SSQ_LIST_WAIT) && measDone
      && (d.st == ssq_pkg::SSQ_LIST_APPLY)
      |=> (q.idx == $past(q.idx) + 1'b1) ##1 srcStrobe)
    else $error("list run skipped or repeated an entry");
  AST_WRAP_TO_FIRST: assert property ( // [RULE21]
    (q.st == ssq_pkg::SSQ_MEM_WAIT) && measDone && !lastPoint
      && (q.loc == `SSQ_LOC_LAST) |=> (q.loc == `SSQ_LOC_FIRST))
    else $error("sweep location did not wrap to first");
  AST_RANGE_REJECT: assert property ( // [RULE22]
    regWr && (regAddr == `SSQ_OFF_CMD) && !q.busy && !argOk
      && (cmdOp == `SSQ_OP_MEM_POINTS)
      |=> (q.errCode == `SSQ_ERR_RANGE) && $stable(q.memPoints))
    else $error("out-of-range count not rejected");
  AST_REVISED_809: assert property ( // [RULE13]
    (q.st == ssq_pkg::SSQ_MEM_APPLY) && exprMissing
      |=> q.errFlag && (q.errCode == `SSQ_ERR_REVISED)
          && !q.active.mathOn && !q.mem[$past(curIdx)].mathOn)
    else $error("missing expression not revised");
  AST_INIT_MATH_OFF: assert property ( // [RULE11]
    regWr && (regAddr == `SSQ_OFF_CMD) && !q.busy
      && (cmdOp == `SSQ_OP_MEM_INIT)
      |=> !q.mem[0].mathOn && !q.mem[`SSQ_MEM_LOCS-1].mathOn
          && (q.mem[`SSQ_MEM_LOCS-1].exprId == `SSQ_EXPR_POWER))
    else $error("memory init left math stage on");
  AST_POINTS_LEGAL: assert property ( // [RULE17]
    (q.memPoints >= 7'h01) && (q.memPoints <= `SSQ_LOC_LAST)
      && (q.memStart >= 7'h01) && (q.memStart <= `SSQ_LOC_LAST))
    else $error("start or point count outside 1 to 100");
  AST_SWEEP_COUNT: assert property ( // [RULE17]
    (q.st == ssq_pkg::SSQ_MEM_WAIT) |-> (q.done < q.memPoints))
    else $error("sweep ran past point count");

  COV_LIST_RUN: cover property (
    (q.st == ssq_pkg::SSQ_LIST_WAIT) && measDone
      && (d.st == ssq_pkg::SSQ_IDLE));
  COV_MEM_WRAP: cover property (
    (q.st == ssq_pkg::SSQ_MEM_APPLY) && (q.loc == `SSQ_LOC_FIRST)
      && (q.done != '0));
  COV_REVISED: cover property (
    (q.st == ssq_pkg::SSQ_MEM_APPLY) && exprMissing);

endmodule

// ### tb/ssq_meas_model.sv
// Measurement path stand-in: answers every trigger with one done pulse.
// Assumes measTrig is a one-cycle pulse on clk_sys.
`timescale 1ns/1ps

module ssq_meas_model (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic measTrig,
  input  wire logic slow,
  output logic      measDone
);
  logic [2:0] waitCnt_q;

  // --------------------------------------------------------------------
  // Responder
  // --------------------------------------------------------------------
  // Slow mode stalls a few cycles so the sequencer must really wait
  always @(posedge clk_sys) begin
    if (!rst_n) begin
      waitCnt_q <= 3'h0;
      measDone  <= 1'b0;
    end else if (measTrig && !slow) begin
      measDone <= 1'b1;
    end else if (measTrig) begin
      waitCnt_q <= 3'h4;
      measDone  <= 1'b0;
    end else begin
      if (waitCnt_q != 3'h0) begin
        waitCnt_q <= waitCnt_q - 3'h1;
      end
      measDone <= (waitCnt_q == 3'h1);
    end
  end
endmodule

// ### tb/ssq_core_tb.sv
// Self-checking bench of the sequencer core: errors, lists, sweeps.
// Assumes ssq_pkg is compiled first and ssq_regs.svh is on the path.
`timescale 1ns/1ps
`include "ssq_regs.svh"

module ssq_core_tb;
  logic                clk_sys     = 1'b0;
  logic                rst_n       = 1'b0;
  logic [7:0]          regAddr     = 8'h00;
  logic [31:0]         regWdata    = 32'h0;
  logic                regWr       = 1'b0;
  logic                regRd       = 1'b0;
  logic [7:0]          exprPresent = 8'h00;
  logic                slow        = 1'b0;
  logic                memRun      = 1'b0;
  logic [31:0]         regRdata;
  logic                measDone;
  logic [15:0]         srcLevel;
  logic                srcIsVolt;
  logic                srcStrobe;
  logic                measTrig;
  logic                seqBusy;
  ssq_pkg::ssq_setup_t activeSetup;
  int                  bad_count   = 0;
  int                  check_count = 0;
  logic [47:0]         capQ[$];
  // Command word beside the error word it should leave
  localparam logic [42:0] ROWS [10] = '{
    {32'h0009, 11'h4DE}, {32'h6509, 11'h4DE}, {32'h000A, 11'h4DE},
    {32'h650A, 11'h4DE}, {32'h000B, 11'h4DE}, {32'h650B, 11'h4DE},
    {32'h000C, 11'h4DE}, {32'h650C, 11'h4DE}, {32'h00FF, 11'h471},
    {32'h640B, 11'h000}};

  ssq_core uut (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .measDone(measDone), .exprPresent(exprPresent),
    .srcLevel(srcLevel), .srcIsVolt(srcIsVolt), .srcStrobe(srcStrobe),
    .measTrig(measTrig), .activeSetup(activeSetup), .seqBusy(seqBusy));
  ssq_meas_model farSide (.clk_sys(clk_sys), .rst_n(rst_n),
    .measTrig(measTrig), .slow(slow), .measDone(measDone));

  always #20 clk_sys = ~clk_sys;

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [47:0] e);
    @(posedge clk_sys);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    // Read data stands only this cycle; look mid-cycle, clear of edges
    @(negedge clk_sys);
    chk({16'h0, regRdata}, e);
  endtask
  task automatic waitIdle();
    int i;
    @(posedge clk_sys);
    for (i = 0; i < 300 && seqBusy !== 1'b0; i++)
      @(posedge clk_sys);
    chk({47'h0, seqBusy}, 48'h0);
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Level or setup at each applied point; trigger paired with it
  // Sampled mid-cycle so the launching edge cannot race the look
  always @(negedge clk_sys) begin
    if (srcStrobe | measTrig)
      chk({47'h0, measTrig}, {47'h0, srcStrobe});
    if (srcStrobe === 1'b1)
      capQ.push_back(memRun ? {activeSetup} : {31'h0, srcIsVolt, srcLevel});
  end

  initial begin
    #(40 * 5000);
    bad_count++;
    print_verdict();
  end

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial begin
    int i;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    chk({45'h0, seqBusy, srcStrobe, measTrig}, 48'h0);
    rd(`SSQ_OFF_MEM_CFG, 48'h00010101);
    rd(8'h3C, 48'h0);
    for (i = 0; i < 10; i++) begin
      wr(`SSQ_OFF_CMD, ROWS[i][42:11]);
      rd(`SSQ_OFF_ERR, {37'h0, ROWS[i][10:0]});
      wr(`SSQ_OFF_ERR, 32'h0);
    end
    wr(`SSQ_OFF_CMD, 32'h0001);
    for (i = 0; i < 3; i++) wr(`SSQ_OFF_LIST_DATA, 32'h0100 + i);
    wr(`SSQ_OFF_CMD, 32'h0003);
    for (i = 0; i < 2; i++) wr(`SSQ_OFF_LIST_DATA, 32'h0200 + i);
    rd(`SSQ_OFF_CUR_LEN, 48'h5);
    wr(`SSQ_OFF_CMD, 32'h0005);
    waitIdle();
    chk(48'(capQ.size()), 48'h5);
    for (i = 0; i < 5; i++)
      chk(capQ[i], i < 3 ? 48'h0100 + i : 48'h01FD + i);
    capQ.delete();
    wr(`SSQ_OFF_CMD, 32'h0002);
    for (i = 0; i < 101; i++) wr(`SSQ_OFF_LIST_DATA, 32'h0300 + i);
    rd(`SSQ_OFF_ERR, 48'h4DF);
    rd(`SSQ_OFF_VOLT_LEN, 48'h64);
    wr(`SSQ_OFF_ERR, 32'h0);
    wr(`SSQ_OFF_CMD, 32'h0002);
    wr(`SSQ_OFF_LIST_DATA, 32'h0777);
    rd(`SSQ_OFF_VOLT_LEN, 48'h1);
    wr(`SSQ_OFF_CMD, 32'h0006);
    waitIdle();
    chk(48'(capQ.size()), 48'h1);
    chk(capQ[0], 48'h10777);
    capQ.delete();
    memRun <= 1'b1;
    slow   <= 1'b1;
    wr(`SSQ_OFF_SETUP_LO, 32'h01C01234);
    wr(`SSQ_OFF_SETUP_HI, 32'h0000AAAA);
    wr(`SSQ_OFF_CMD, 32'h6409);
    wr(`SSQ_OFF_SETUP_LO, 32'h00008005);
    wr(`SSQ_OFF_SETUP_HI, 32'h00005555);
    wr(`SSQ_OFF_CMD, 32'h0109);
    wr(`SSQ_OFF_CMD, 32'h640B);
    wr(`SSQ_OFF_CMD, 32'h020C);
    wr(`SSQ_OFF_CMD, 32'h0007);
    waitIdle();
    chk(48'(capQ.size()), 48'h2);
    chk(capQ[0], 48'hAAAA01801234);
    chk(capQ[1], 48'h555500008005);
    rd(`SSQ_OFF_ERR, 48'h729);
    wr(`SSQ_OFF_CMD, 32'h640A);
    @(posedge clk_sys);
    chk(activeSetup, 48'hAAAA01801234);
    wr(`SSQ_OFF_SETUP_LO, 32'h01C01234);
    wr(`SSQ_OFF_SETUP_HI, 32'h00007777);
    rd(`SSQ_OFF_SETUP_HI, 48'h7777);
    wr(`SSQ_OFF_CMD, 32'h0008);
    wr(`SSQ_OFF_CMD, 32'h320A);
    @(posedge clk_sys);
    chk(activeSetup, 48'h777700001234);
    wr(`SSQ_OFF_CMD, 32'h010A);
    @(posedge clk_sys);
    chk(activeSetup, 48'h777700001234);
    print_verdict();
  end
endmodule
